// file: startup_config_loader_regs.vh
// Purpose: constants for the start-up configuration loader
// Assumes: byte-wide nonvolatile memory with a one-cycle read latency
// Notes:   addresses are nonvolatile byte addresses
// Operation
// - config bit 4 clear: two-wire address from straps; set: from stored byte
// - config bit 3 clear leaves scan interface on; set disables it
// - config bits 2..0 pick host port; top bit set defers to straps
// - secure-module bus address always comes from the stored byte
// - protocol area holds 16 transmit and 8 receive bytes per protocol
// - every start-up loads registers from the stored reset image
// - reset image starts at 0x40, one byte per register in order
// - protocol load command copies protocol settings into registers at run time
// - page 0 holds part identifier, version and trim bytes, read-only
// - configuration byte sits at address 0x21
// - strap address is 10101 followed by the two strap pins
// - config bit 7 clear: fast mode; set: fast-plus mode
// - start-up copy runs by itself with no host command
`ifndef STARTUP_CONFIG_LOADER_REGS_VH
`define STARTUP_CONFIG_LOADER_REGS_VH
`define NV_ADDR_W          13
`define NV_ID_ADDR         13'h0000
`define NV_VERSION_ADDR    13'h0003
`define NV_ADDR_BYTE       13'h0020
`define NV_CFG_BYTE        13'h0021
`define NV_SAM_ADDR_BYTE   13'h0022
`define NV_IMAGE_BASE      13'h0040
`define NV_IMAGE_LEN       8'h80
`define NV_ID_READS        8'h06
`define NV_PROTO_TX_BASE   13'h1C00
`define NV_PROTO_RX_BASE   13'h1C00
`define PROTO_TX_LEN       8'h10
`define PROTO_RX_LEN       8'h08
`define PROTO_TX_REG       8'h28
`define PROTO_RX_REG       8'h38
`define CFG_HSP_BIT        7
`define CFG_ADDR_SRC_BIT   4
`define CFG_SCAN_OFF_BIT   3
`define HOST_UART          3'h0
`define HOST_TWO_WIRE      3'h1
`define HOST_SPI           3'h2
`define HOST_ALT_TWO_WIRE  3'h3
`define STRAP_ADDR_PREFIX  5'h15
`endif

// file: startup_config_loader.v
// Purpose: read configuration and register reset image after reset, serve protocol loads
// Assumes: nv_rdata_i holds the addressed byte while nv_rd_o is up; taken at the next edge
// Notes:   registers are written through reg_we_o / reg_addr_o / reg_wdata_o
`timescale 1ns/10ps
`default_nettype none
`include "startup_config_loader_regs.vh"
module startup_config_loader #(
  parameter PROTO_TX_COUNT = 16,
  parameter PROTO_RX_COUNT = 16
) (
  input  wire        clock_i,
  input  wire        srst_i,
  input  wire        iface_strap_low_i,
  input  wire        iface_strap_high_i,
  input  wire [2:0]  iface_strap_sel_i,
  input  wire        protocol_load_cmd_i,
  input  wire [7:0]  proto_rx_num_i,
  input  wire [7:0]  proto_tx_num_i,
  input  wire [7:0]  nv_rdata_i,
  output reg         nv_rd_o,
  output reg  [12:0] nv_addr_o,
  output reg         reg_we_o,
  output reg  [7:0]  reg_addr_o,
  output reg  [7:0]  reg_wdata_o,
  output reg  [6:0]  host_bus_addr_o,
  output reg  [6:0]  secure_module_bus_addr_o,
  output reg  [2:0]  host_port_sel_o,
  output reg         fast_two_wire_variant_sel_o,
  output reg         scan_enable_o,
  output reg  [23:0] part_identifier_o,
  output reg  [7:0]  silicon_version_o,
  output reg         host_ready_o,
  output reg         proto_busy_o,
  output reg         proto_err_o
);

  // ==========================================================================
  // sequencer
  localparam ST_ID    = 3'd0;
  localparam ST_CFG   = 3'd1;
  localparam ST_IMAGE = 3'd2;
  localparam ST_IDLE  = 3'd3;
  localparam ST_TX    = 3'd4;
  localparam ST_RX    = 3'd5;

  reg [2:0]  state;
  reg [7:0]  idx;
  reg        pend;      // read issued last cycle, data now on nv_rdata_i
  reg [7:0]  pend_idx;
  reg [7:0]  len;
  reg [7:0]  rx_num;
  reg [7:0]  stored_addr;
  reg [7:0]  cfg;
  reg [7:0]  tx_num;    // held for the whole load, the command inputs may move on
  reg [12:0] id_addr;
  reg [12:0] burst_base;
  reg [7:0]  target_addr;

  // rx sets sit behind all tx sets; the tx count is a parameter, so the
  // offset is worked out from it rather than written down
  wire [12:0] tx_base    = `NV_PROTO_TX_BASE + {1'b0, tx_num, 4'h0};
  wire [12:0] rx_base    = `NV_PROTO_TX_BASE + {1'b0, PROTO_TX_COUNT[7:0], 4'h0}
                           + {2'b00, rx_num, 3'h0};
  wire [6:0]  strap_addr = {`STRAP_ADDR_PREFIX, iface_strap_high_i, iface_strap_low_i};
  // selection may only follow cfg once the byte has been read in
  wire        cfg_loaded = (state != ST_ID) && (state != ST_CFG);

  // ==========================================================================
  // address decode
  always @* begin
    if (idx < 8'h04) begin
      id_addr = `NV_ID_ADDR + {5'h00, idx};
    end else if (idx == 8'h04) begin
      id_addr = `NV_ADDR_BYTE;
    end else begin
      id_addr = `NV_SAM_ADDR_BYTE;
    end
  end

  always @* begin
    if (state == ST_TX) begin
      burst_base = tx_base;
    end else if (state == ST_RX) begin
      burst_base = rx_base;
    end else begin
      burst_base = `NV_IMAGE_BASE;
    end
  end

  // register writes trail the reads by one cycle, so the target follows pend_idx
  always @* begin
    if (state == ST_TX) begin
      target_addr = `PROTO_TX_REG + pend_idx;
    end else if (state == ST_RX) begin
      target_addr = `PROTO_RX_REG + pend_idx;
    end else begin
      target_addr = pend_idx;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      state         <= ST_ID;
      idx           <= 8'h00;
      len           <= `NV_ID_READS;
      pend          <= 1'b0;
      pend_idx      <= 8'h00;
      rx_num        <= 8'h00;
      tx_num        <= 8'h00;
      nv_rd_o       <= 1'b0;
      nv_addr_o     <= 13'h0000;
      reg_we_o      <= 1'b0;
      reg_addr_o    <= 8'h00;
      reg_wdata_o   <= 8'h00;
      stored_addr   <= 8'h00;
      cfg           <= 8'h80;
      part_identifier_o <= 24'h000000;
      silicon_version_o <= 8'h00;
      host_ready_o  <= 1'b0;
      proto_busy_o  <= 1'b0;
      proto_err_o   <= 1'b0;
      secure_module_bus_addr_o <= 7'h00;
    end else begin
      pend     <= 1'b0;
      nv_rd_o  <= 1'b0;
      reg_we_o <= 1'b0;
      // capture data of the previous read
      if (pend) begin
        case (state)
          ST_ID: begin
            if (pend_idx < 8'h03)
              part_identifier_o <= {part_identifier_o[15:0], nv_rdata_i};
            else if (pend_idx == 8'h03)
              silicon_version_o <= nv_rdata_i;
            else if (pend_idx == 8'h04)
              stored_addr <= nv_rdata_i;
            else
              secure_module_bus_addr_o <= nv_rdata_i[6:0];
          end
          ST_CFG: cfg <= nv_rdata_i;
          default: begin
            reg_we_o    <= 1'b1;
            reg_wdata_o <= nv_rdata_i;
            reg_addr_o  <= target_addr;
          end
        endcase
      end
      case (state)
        ST_ID: begin
          // ids at 0..3, stored two-wire address 0x20, secure-module address 0x22
          if (idx < len) begin
            nv_rd_o   <= 1'b1;
            nv_addr_o <= id_addr;
            pend      <= 1'b1;
            pend_idx  <= idx;
            idx       <= idx + 8'h01;
          end else if (!pend) begin
            state     <= ST_CFG;
            nv_rd_o   <= 1'b1;
            nv_addr_o <= `NV_CFG_BYTE;
            pend      <= 1'b1;
          end
        end
        ST_CFG: begin
          if (pend) begin
            state <= ST_IMAGE;
            idx   <= 8'h00;
            len   <= `NV_IMAGE_LEN;
          end
        end
        ST_IMAGE, ST_TX, ST_RX: begin
          if (idx < len) begin
            nv_rd_o   <= 1'b1;
            nv_addr_o <= burst_base + {5'h00, idx};
            pend      <= 1'b1;
            pend_idx  <= idx;
            idx       <= idx + 8'h01;
          end else if (!pend) begin
            idx <= 8'h00;
            if (state == ST_TX) begin
              state <= ST_RX;
              len   <= `PROTO_RX_LEN;
            end else begin
              state        <= ST_IDLE;
              proto_busy_o <= 1'b0;
              host_ready_o <= 1'b1;
            end
          end
        end
        default: begin
          if (protocol_load_cmd_i) begin
            if (proto_tx_num_i >= PROTO_TX_COUNT[7:0] ||
                proto_rx_num_i >= PROTO_RX_COUNT[7:0]) begin
              proto_err_o <= 1'b1;
            end else begin
              proto_err_o  <= 1'b0;
              proto_busy_o <= 1'b1;
              rx_num       <= proto_rx_num_i;
              tx_num       <= proto_tx_num_i;
              state        <= ST_TX;
              idx          <= 8'h00;
              len          <= `PROTO_TX_LEN;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // host interface selection
  // follows the straps every cycle once cfg is in, so the selection already
  // stands when host_ready_o rises; bits 6 and 5 of cfg are never read
  always @(posedge clock_i) begin
    if (srst_i) begin
      host_bus_addr_o             <= 7'h00;
      host_port_sel_o             <= 3'h0;
      fast_two_wire_variant_sel_o <= 1'b1;
      scan_enable_o               <= 1'b1;
    end else if (cfg_loaded) begin
      fast_two_wire_variant_sel_o <= cfg[`CFG_HSP_BIT];
      scan_enable_o               <= ~cfg[`CFG_SCAN_OFF_BIT];
      host_port_sel_o             <= cfg[2] ? iface_strap_sel_i : cfg[2:0];
      host_bus_addr_o             <= cfg[`CFG_ADDR_SRC_BIT] ? stored_addr[6:0] : strap_addr;
    end
  end

endmodule // startup_config_loader
`default_nettype wire

// file: startup_config_loader_properties.sv
// Purpose: port checks for the start-up configuration loader
// Assumes: one clock domain, synchronous reset
// Notes:   bound to the design top module
`timescale 1ns/10ps
`default_nettype none
module startup_config_loader_properties (
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        protocol_load_cmd_i,
  input wire logic        nv_rd_o,
  input wire logic [12:0] nv_addr_o,
  input wire logic        reg_we_o,
  input wire logic [7:0]  reg_addr_o,
  input wire logic        host_ready_o,
  input wire logic        proto_busy_o,
  input wire logic        proto_err_o
);
  // ==========
  // properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence s_cmd;
    protocol_load_cmd_i && host_ready_o && !proto_busy_o;
  endsequence
  a_write_after_read: assert property (reg_we_o |-> $past(nv_rd_o))
    else $error("register write without a memory read");
  a_image_pairing: assert property (reg_we_o && !host_ready_o |->
    {5'h00, reg_addr_o} + 13'h0040 == $past(nv_addr_o))
    else $error("image byte went to the wrong register");
  a_proto_target: assert property (reg_we_o && host_ready_o |->
    reg_addr_o inside {[8'h28:8'h3F]})
    else $error("protocol write outside its register window");
  a_cmd_starts: assert property (s_cmd |-> ##[1:2] (proto_busy_o || proto_err_o))
    else $error("protocol load command not taken");
  a_busy_bounded: assert property ($rose(proto_busy_o) |->
    proto_busy_o[*8] ##[17:40] !proto_busy_o)
    else $error("protocol load length wrong");
  a_cmd_refused: assert property (protocol_load_cmd_i && !host_ready_o |=> !proto_busy_o)
    else $error("command taken before ready");
  a_startup_auto: assert property ($fell(srst_i) |-> ##[128:400] host_ready_o)
    else $error("start-up copy did not finish");
  a_idle_quiet: assert property (host_ready_o && !proto_busy_o |-> !nv_rd_o)
    else $error("memory read while idle");
endmodule // startup_config_loader_properties
bind startup_config_loader startup_config_loader_properties props_inst (
  .clock_i(clock_i), .srst_i(srst_i), .protocol_load_cmd_i(protocol_load_cmd_i),
  .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o), .reg_we_o(reg_we_o),
  .reg_addr_o(reg_addr_o), .host_ready_o(host_ready_o),
  .proto_busy_o(proto_busy_o), .proto_err_o(proto_err_o));
`default_nettype wire

// file: nv_memory_model.sv
// Purpose: byte-wide nonvolatile memory, read data taken one edge after the request
// Assumes: contents are loaded by the bench
// Notes:   outside read cycles the inverse of the addressed byte shows
`timescale 1ns/10ps
`default_nettype none
module nv_memory_model (
  input  wire logic        rd_i,
  input  wire logic [12:0] addr_i,
  output wire logic [7:0]  rdata_o
);
  // ==========
  // storage
  logic [7:0] mem [0:8191];
  // the byte shows only while the read is raised, so a sample taken a cycle
  // early or late sees its inverse and cannot pass by luck
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule // nv_memory_model
`default_nettype wire

// file: startup_config_loader_bench.sv
// Purpose: self-checking bench for the start-up configuration loader
// Assumes: straps, reset image bytes and config byte are redrawn per start-up; the rest of memory is random once
// Notes:   protocol set counts shrunk to 4
`timescale 1ns/10ps
`default_nettype none
module startup_config_loader_bench;
  localparam int TX = 4;
  logic clock_i = 0, srst_i = 1, sl = 0, sh = 0, cmd = 0;
  logic [2:0] ss = 0;
  logic [7:0] rxn = 0, txn = 0, cfg;
  wire [7:0] rd, wa, wd, ver;
  wire [12:0] na;
  wire nr, we, rdy, busy, perr, scan, fast;
  wire [6:0] ha, sa;
  wire [2:0] hs;
  wire [23:0] pid;
  int err_count = 0, tests_run = 0, writes = 0;
  logic [31:0] s = 11054;
  always #10 clock_i = ~clock_i;
  nv_memory_model nv_memory_model_inst (.rd_i(nr), .addr_i(na), .rdata_o(rd));
  startup_config_loader #(.PROTO_TX_COUNT(TX), .PROTO_RX_COUNT(4)) startup_config_loader_inst (
    .clock_i(clock_i), .srst_i(srst_i), .iface_strap_low_i(sl), .iface_strap_high_i(sh),
    .iface_strap_sel_i(ss), .protocol_load_cmd_i(cmd), .proto_rx_num_i(rxn),
    .proto_tx_num_i(txn), .nv_rdata_i(rd), .nv_rd_o(nr), .nv_addr_o(na), .reg_we_o(we),
    .reg_addr_o(wa), .reg_wdata_o(wd), .host_bus_addr_o(ha), .secure_module_bus_addr_o(sa),
    .host_port_sel_o(hs), .fast_two_wire_variant_sel_o(fast), .scan_enable_o(scan),
    .part_identifier_o(pid), .silicon_version_o(ver), .host_ready_o(rdy),
    .proto_busy_o(busy), .proto_err_o(perr));
  function automatic logic [7:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic idle_wait(input logic lvl);
    for (int t = 0; t < 400 && (lvl ? !rdy : busy); t++) @(negedge clock_i);
  endtask
  // ==========
  // reference model of every register write
  always @(posedge clock_i) begin
    if (we) begin
      writes++;
      if (!rdy) check(wd, nv_memory_model_inst.mem[13'h0040 + wa]);
      else if (wa < 8'h38) check(wd, nv_memory_model_inst.mem[7168 + 16 * txn + wa - 8'h28]);
      else check(wd, nv_memory_model_inst.mem[7168 + 16 * TX + 8 * rxn + wa - 8'h38]);
    end
  end
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 8192; i++) nv_memory_model_inst.mem[i] = xs();
    for (int k = 0; k < 8; k++) begin
      for (int i = 64; i < 192; i++) nv_memory_model_inst.mem[i] = xs();
      cfg = xs();
      cfg[2:0] = k[2:0];
      nv_memory_model_inst.mem[33] = cfg;
      {sl, sh, ss} = 5'(xs());
      srst_i = 1;
      repeat (3) @(negedge clock_i);
      srst_i = 0;
      writes = 0;
      cmd = k[0];
      @(negedge clock_i);
      cmd = 0;
      idle_wait(1);
      check(rdy, 1);
      check(writes, 128);
      check(hs, cfg[2] ? ss : cfg[2:0]);
      check(ha, cfg[4] ? nv_memory_model_inst.mem[32][6:0] : {5'h15, sh, sl});
      check(sa, nv_memory_model_inst.mem[34][6:0]);
      check(scan, !cfg[3]);
      check(fast, cfg[7]);
      check(pid, {nv_memory_model_inst.mem[0], nv_memory_model_inst.mem[1], nv_memory_model_inst.mem[2]});
      check(ver, nv_memory_model_inst.mem[3]);
    end
    for (int j = 0; j < 2; j++) begin
      txn = j ? 8'h04 : 8'h03;
      rxn = 8'h02;
      writes = 0;
      cmd = 1;
      @(negedge clock_i);
      cmd = 0;
      @(negedge clock_i);
      check({busy, perr}, j ? 2'b01 : 2'b10);
      idle_wait(0);
      check(writes, j ? 0 : 24);
    end
    summarize();
  end
endmodule // startup_config_loader_bench
`default_nettype wire
